// ### rtl/imx_pkg.sv
package imx_pkg;
   // Clock and timing
   localparam int CLK_NS = 10;
   localparam int RST_MIN_NS = 500;
   localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] RST_MIN_CNT = 8'(RST_MIN_CYC);
   localparam int SCL_QTR_NS = 2500;
   localparam int SCL_QTR_CYC = SCL_QTR_NS / CLK_NS;
   localparam logic [7:0] SCL_QTR_CNT = 8'(SCL_QTR_CYC - 1);
   // Byte framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Channel register
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam int CH_EN_BIT = 3;
   // Upper address bits, arbitrary value
   localparam logic [3:0] ADDR_HI = 4'he;
   // Host register map (byte addresses)
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RDATA = 4'h8;
   // Command and status field positions
   localparam int CMD_RW_BIT = 7;
   localparam int CMD_WD_LSB = 8;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_NACK_BIT = 1;

   typedef enum logic [2:0] {
      DS_IDLE = 3'b000,
      DS_ADDR = 3'b001,
      DS_ACK = 3'b010,
      DS_WDATA = 3'b011,
      DS_RDATA = 3'b100,
      DS_RACK = 3'b101
   } imx_dstate_t;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_START = 2'b01,
      HS_BIT = 2'b10,
      HS_STOP = 2'b11
   } imx_hstate_t;
endpackage

// ### rtl/imx_link_if.sv
`timescale 1ns/100ps
interface imx_link_if;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl;
   logic sda;
   // Open-drain wired AND, pull-ups give high
   assign scl = ~(~host_scl_oe_n & ~host_scl_o);
   assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
   modport host (output host_scl_o, output host_scl_oe_n, output host_sda_o, output host_sda_oe_n,
                 input scl, input sda);
   modport dev (output dev_sda_o, output dev_sda_oe_n, input scl, input sda);
endinterface

// ### rtl/imx_dev.sv
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
module imx_dev (
   input wire logic ref_clk,
   input wire logic nrst,
   imx_link_if.dev link,
   input wire logic rst_pin_n,
   input wire logic addr_select_0,
   input wire logic addr_select_1,
   input wire logic addr_select_2,
   output logic [7:0] channel_reg,
   output logic [7:0] channel_connect
);
   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic rst_m;
      logic rst_s;
      logic [2:0] adr_m;
      logic [2:0] adr_s;
      logic [7:0] rst_cnt;
      imx_pkg::imx_dstate_t st;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic rw;
      logic ack_seen;
      logic [7:0] ctrl;
      logic [7:0] pend;
      logic pend_v;
      logic sda_oe_n;
      logic [7:0] conn;
   } imx_dev_t;

   imx_dev_t s_ff;
   imx_dev_t nxt_s;
   logic start_c;
   logic stop_c;
   logic scl_rise;
   logic scl_fall;

   // One-hot pass-gate enables from the channel byte
   function automatic logic [7:0] imx_decode(input logic [7:0] c);
      imx_decode = 8'h00;
      if (c[imx_pkg::CH_EN_BIT])
         imx_decode[c[2:0]] = 1'b1;
   endfunction

   // Bus conditions, read only from settled sync stages
   always_comb
   begin
      start_c = s_ff.scl_s & s_ff.scl_p & s_ff.sda_p & ~s_ff.sda_s;
      stop_c = s_ff.scl_s & s_ff.scl_p & ~s_ff.sda_p & s_ff.sda_s;
      scl_rise = s_ff.scl_s & ~s_ff.scl_p;
      scl_fall = ~s_ff.scl_s & s_ff.scl_p;
   end

   always_comb
   begin
      nxt_s = s_ff;
      // Two-stage synchronisers for every pin
      nxt_s.scl_m = link.scl;
      nxt_s.scl_s = s_ff.scl_m;
      nxt_s.scl_p = s_ff.scl_s;
      nxt_s.sda_m = link.sda;
      nxt_s.sda_s = s_ff.sda_m;
      nxt_s.sda_p = s_ff.sda_s;
      nxt_s.rst_m = rst_pin_n;
      nxt_s.rst_s = s_ff.rst_m;
      nxt_s.adr_m = {addr_select_2, addr_select_1, addr_select_0};
      nxt_s.adr_s = s_ff.adr_m;
      // Width filter: short glitches on the reset pin are ignored
      if (s_ff.rst_s)
         nxt_s.rst_cnt = 8'h00;
      else if (s_ff.rst_cnt != imx_pkg::RST_MIN_CNT)
         nxt_s.rst_cnt = s_ff.rst_cnt + 8'h01;

      if (start_c)
      begin
         // Repeated start is accepted from any state
         nxt_s.st = imx_pkg::DS_ADDR;
         nxt_s.cnt = 4'h0;
         nxt_s.sda_oe_n = 1'b1;
      end
      else if (stop_c)
      begin
         nxt_s.st = imx_pkg::DS_IDLE;
         nxt_s.sda_oe_n = 1'b1;
         if (s_ff.pend_v)
         begin
            nxt_s.ctrl = s_ff.pend;
            nxt_s.pend_v = 1'b0;
         end
      end
      else
      begin
         unique case (s_ff.st)
            imx_pkg::DS_IDLE:
            begin
               nxt_s.sda_oe_n = 1'b1;
            end
            imx_pkg::DS_ADDR:
            begin
               if (scl_rise)
               begin
                  nxt_s.shreg = {s_ff.shreg[6:0], s_ff.sda_s};
                  nxt_s.cnt = s_ff.cnt + 4'h1;
               end
               else if (scl_fall && s_ff.cnt == imx_pkg::BITS_PER_BYTE)
               begin
                  // Upper bits fixed, lower three from the strap pins
                  if (s_ff.shreg[7:1] == {imx_pkg::ADDR_HI, s_ff.adr_s})
                  begin
                     nxt_s.st = imx_pkg::DS_ACK;
                     nxt_s.rw = s_ff.shreg[0];
                     nxt_s.sda_oe_n = 1'b0;
                  end
                  else
                     nxt_s.st = imx_pkg::DS_IDLE;
               end
            end
            imx_pkg::DS_ACK:
            begin
               // Held low from fall to fall covers the whole high phase
               if (scl_fall)
               begin
                  nxt_s.cnt = 4'h0;
                  if (s_ff.rw)
                  begin
                     nxt_s.st = imx_pkg::DS_RDATA;
                     nxt_s.shreg = s_ff.ctrl;
                     nxt_s.sda_oe_n = s_ff.ctrl[7];
                  end
                  else
                  begin
                     nxt_s.st = imx_pkg::DS_WDATA;
                     nxt_s.sda_oe_n = 1'b1;
                  end
               end
            end
            imx_pkg::DS_WDATA:
            begin
               if (scl_rise)
               begin
                  nxt_s.shreg = {s_ff.shreg[6:0], s_ff.sda_s};
                  nxt_s.cnt = s_ff.cnt + 4'h1;
               end
               else if (scl_fall && s_ff.cnt == imx_pkg::BITS_PER_BYTE)
               begin
                  // Overwrites any earlier byte; no count limit
                  nxt_s.pend = s_ff.shreg;
                  nxt_s.pend_v = 1'b1;
                  nxt_s.st = imx_pkg::DS_ACK;
                  nxt_s.sda_oe_n = 1'b0;
               end
            end
            imx_pkg::DS_RDATA:
            begin
               if (scl_rise)
                  nxt_s.cnt = s_ff.cnt + 4'h1;
               else if (scl_fall)
               begin
                  if (s_ff.cnt == imx_pkg::BITS_PER_BYTE)
                  begin
                     nxt_s.st = imx_pkg::DS_RACK;
                     nxt_s.sda_oe_n = 1'b1;
                  end
                  else
                  begin
                     // Next bit set up while clock is low
                     nxt_s.shreg = {s_ff.shreg[6:0], 1'b0};
                     nxt_s.sda_oe_n = s_ff.shreg[6];
                  end
               end
            end
            imx_pkg::DS_RACK:
            begin
               if (scl_rise)
                  nxt_s.ack_seen = ~s_ff.sda_s;
               else if (scl_fall)
               begin
                  nxt_s.cnt = 4'h0;
                  if (s_ff.ack_seen)
                  begin
                     nxt_s.st = imx_pkg::DS_RDATA;
                     nxt_s.shreg = s_ff.ctrl;
                     nxt_s.sda_oe_n = s_ff.ctrl[7];
                  end
                  else
                  begin
                     // Line left high so the master can stop
                     nxt_s.st = imx_pkg::DS_IDLE;
                     nxt_s.sda_oe_n = 1'b1;
                  end
               end
            end
            default:
            begin
               nxt_s.st = imx_pkg::DS_IDLE;
               nxt_s.sda_oe_n = 1'b1;
            end
         endcase
      end

      // Filtered reset pin: back to defaults, only channel 0
      if (s_ff.rst_cnt == imx_pkg::RST_MIN_CNT)
      begin
         nxt_s.st = imx_pkg::DS_IDLE;
         nxt_s.ctrl = imx_pkg::CTRL_RESET;
         nxt_s.pend_v = 1'b0;
         nxt_s.sda_oe_n = 1'b1;
         nxt_s.cnt = 4'h0;
      end
      nxt_s.conn = imx_decode(nxt_s.ctrl);
   end

   // Power-on reset modelled by nrst
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         s_ff <= '0;
         s_ff.scl_m <= 1'b1;
         s_ff.scl_s <= 1'b1;
         s_ff.scl_p <= 1'b1;
         s_ff.sda_m <= 1'b1;
         s_ff.sda_s <= 1'b1;
         s_ff.sda_p <= 1'b1;
         s_ff.rst_m <= 1'b1;
         s_ff.rst_s <= 1'b1;
         s_ff.st <= imx_pkg::DS_IDLE;
         s_ff.ctrl <= imx_pkg::CTRL_RESET;
         s_ff.sda_oe_n <= 1'b1;
         s_ff.conn <= imx_decode(imx_pkg::CTRL_RESET);
      end
      else
         s_ff <= nxt_s;
   end

   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe_n = s_ff.sda_oe_n;
   assign channel_reg = s_ff.ctrl;
   assign channel_connect = s_ff.conn;
endmodule

// ### rtl/imx_host.sv
`timescale 1ns/100ps
module imx_host (
   input wire logic ref_clk,
   input wire logic nrst,
   imx_link_if.host link,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   typedef struct packed {
      logic sda_m;
      logic sda_s;
      logic [7:0] tick;
      logic [1:0] ph;
      imx_pkg::imx_hstate_t st;
      logic [3:0] bitn;
      logic byte1;
      logic [7:0] shreg;
      logic [7:0] wdata;
      logic rw;
      logic [7:0] rdata;
      logic nack;
      logic scl_oe_n;
      logic sda_oe_n;
      logic wait_n;
      logic [31:0] rdd;
   } imx_host_t;

   imx_host_t s_ff;
   imx_host_t nxt_s;
   logic qtick;
   logic tx;

   always_comb
   begin
      qtick = (s_ff.tick == imx_pkg::SCL_QTR_CNT);
      tx = ~s_ff.byte1 | ~s_ff.rw;
   end

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.sda_m = link.sda;
      nxt_s.sda_s = s_ff.sda_m;
      // Divider for the bus clock quarter periods
      if (s_ff.st == imx_pkg::HS_IDLE || qtick)
         nxt_s.tick = 8'h00;
      else
         nxt_s.tick = s_ff.tick + 8'h01;

      // Avalon slave: one wait cycle, then answer
      nxt_s.wait_n = 1'b0;
      if ((avs_read || avs_write) && !s_ff.wait_n)
      begin
         nxt_s.wait_n = 1'b1;
         unique case (avs_address)
            imx_pkg::REG_STATUS:
               nxt_s.rdd = {30'h0, s_ff.nack, s_ff.st != imx_pkg::HS_IDLE};
            imx_pkg::REG_RDATA:
               nxt_s.rdd = {24'h0, s_ff.rdata};
            default:
               nxt_s.rdd = 32'h0;
         endcase
      end

      unique case (s_ff.st)
         imx_pkg::HS_IDLE:
         begin
            nxt_s.scl_oe_n = 1'b1;
            nxt_s.sda_oe_n = 1'b1;
            nxt_s.ph = 2'h0;
            // Commands only launch from idle; busy writes are dropped
            if (avs_write && s_ff.wait_n && avs_address == imx_pkg::REG_CMD)
            begin
               nxt_s.st = imx_pkg::HS_START;
               // Address goes out first, direction bit last on the wire
               nxt_s.shreg = {avs_writedata[imx_pkg::CMD_RW_BIT - 1:0], avs_writedata[imx_pkg::CMD_RW_BIT]};
               nxt_s.rw = avs_writedata[imx_pkg::CMD_RW_BIT];
               nxt_s.wdata = avs_writedata[imx_pkg::CMD_WD_LSB +: 8];
               nxt_s.byte1 = 1'b0;
               nxt_s.bitn = 4'h0;
               nxt_s.nack = 1'b0;
            end
         end
         imx_pkg::HS_START:
         begin
            if (qtick)
            begin
               nxt_s.ph = s_ff.ph + 2'h1;
               if (s_ff.ph == 2'h0)
                  nxt_s.sda_oe_n = 1'b0;
               else
               begin
                  nxt_s.scl_oe_n = 1'b0;
                  nxt_s.st = imx_pkg::HS_BIT;
                  nxt_s.ph = 2'h0;
               end
            end
         end
         imx_pkg::HS_BIT:
         begin
            if (qtick)
            begin
               nxt_s.ph = s_ff.ph + 2'h1;
               unique case (s_ff.ph)
                  2'h0:
                  begin
                     // Data moves only with the clock low
                     if (s_ff.bitn != imx_pkg::BITS_PER_BYTE)
                        nxt_s.sda_oe_n = tx ? s_ff.shreg[7] : 1'b1;
                     else
                        nxt_s.sda_oe_n = 1'b1;
                  end
                  2'h1:
                     nxt_s.scl_oe_n = 1'b1;
                  2'h2:
                  begin
                     if (s_ff.bitn != imx_pkg::BITS_PER_BYTE)
                        nxt_s.shreg = {s_ff.shreg[6:0], s_ff.sda_s};
                     else if (tx)
                        nxt_s.nack = s_ff.sda_s;
                  end
                  2'h3:
                  begin
                     nxt_s.scl_oe_n = 1'b0;
                     nxt_s.bitn = s_ff.bitn + 4'h1;
                     if (s_ff.bitn == imx_pkg::BITS_PER_BYTE)
                     begin
                        nxt_s.bitn = 4'h0;
                        if (tx && s_ff.nack)
                           nxt_s.st = imx_pkg::HS_STOP;
                        else if (!s_ff.byte1)
                        begin
                           nxt_s.byte1 = 1'b1;
                           nxt_s.shreg = s_ff.wdata;
                        end
                        else
                        begin
                           if (!tx)
                              nxt_s.rdata = s_ff.shreg;
                           nxt_s.st = imx_pkg::HS_STOP;
                        end
                     end
                  end
                  default:
                     nxt_s.ph = 2'h0;
               endcase
            end
         end
         imx_pkg::HS_STOP:
         begin
            if (qtick)
            begin
               nxt_s.ph = s_ff.ph + 2'h1;
               unique case (s_ff.ph)
                  2'h0:
                     nxt_s.sda_oe_n = 1'b0;
                  2'h1:
                     nxt_s.scl_oe_n = 1'b1;
                  2'h2:
                     nxt_s.sda_oe_n = 1'b1;
                  default:
                     nxt_s.st = imx_pkg::HS_IDLE;
               endcase
            end
         end
         default:
            nxt_s.st = imx_pkg::HS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         s_ff <= '0;
         s_ff.sda_m <= 1'b1;
         s_ff.sda_s <= 1'b1;
         s_ff.st <= imx_pkg::HS_IDLE;
         s_ff.scl_oe_n <= 1'b1;
         s_ff.sda_oe_n <= 1'b1;
      end
      else
         s_ff <= nxt_s;
   end

   assign link.host_scl_o = 1'b0;
   assign link.host_sda_o = 1'b0;
   assign link.host_scl_oe_n = s_ff.scl_oe_n;
   assign link.host_sda_oe_n = s_ff.sda_oe_n;
   assign avs_readdata = s_ff.rdd;
   assign avs_waitrequest = ~s_ff.wait_n;
endmodule

// ### verif/imx_link_properties.sv
`timescale 1ns/100ps
module imx_link_properties (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic host_scl_o,
   input wire logic host_scl_oe_n,
   input wire logic host_sda_o,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   // Open-drain ends may only ever pull low, pull-ups give the high level
   a_open_drain_only: assert property (@(posedge ref_clk) disable iff (!nrst)
      !host_scl_o && !host_sda_o && !dev_sda_o)
      else $error("a link end drives a line actively high");
   // Reset must release every line; no disable so the reset cycles are seen
   a_reset_releases: assert property (@(posedge ref_clk) disable iff (1'b0)
      !nrst |=> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n)
      else $error("line still pulled low after reset");
   // Device changes its data drive only with the clock low on both edges
   a_dev_edge_low: assert property (@(posedge ref_clk) disable iff (!nrst)
      $changed(dev_sda_oe_n) |-> !scl && !$past(scl))
      else $error("device moved data while clock high");
   // Master never moves clock and data in the same cycle, so no false condition
   a_host_one_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
      !($changed(host_scl_oe_n) && $changed(host_sda_oe_n)))
      else $error("master moved clock and data together");
   // An acknowledge or data low from the device stands for the first 8 cycles of the high phase
   a_ack_holds_high: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(scl) && !dev_sda_oe_n |-> (!dev_sda_oe_n) [*8])
      else $error("device released data during clock high");
   // A start is followed by the clock going low a quarter period later
   a_start_then_clk: assert property (@(posedge ref_clk) disable iff (!nrst)
      $fell(sda) && scl |-> ##[1:300] !scl)
      else $error("clock not lowered after start");
   // After a stop both lines stay released for three cycles
   a_stop_leaves_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(sda) && scl |-> (scl && sda && dev_sda_oe_n) [*3])
      else $error("bus not idle after stop");
   // Each clock pulse has a bounded high phase ending in a fall or a stop
   a_clk_high_width: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(scl) |-> scl [*8] ##[1:600] ($fell(scl) || $rose(sda)))
      else $error("clock high phase out of range");
   c_start: cover property (@(posedge ref_clk) disable iff (!nrst) $fell(sda) && scl);
   c_dev_ack: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(scl) && !dev_sda_oe_n);
   c_stop: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(sda) && scl);
endmodule

// ### verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic rst_pin_n = 1'b1;
   logic [2:0] strap = 3'h0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] channel_reg;
   logic [7:0] channel_connect;
   int fail_count = 0;
   int cmp_count = 0;
   int seed = 30;
   logic [7:0] d1;
   logic [6:0] me;
   logic [31:0] q;

   imx_link_if link();
   imx_host u_imx_host (.ref_clk(ref_clk), .nrst(nrst), .link(link), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   imx_dev u_imx_dev (.ref_clk(ref_clk), .nrst(nrst), .link(link), .rst_pin_n(rst_pin_n),
      .addr_select_0(strap[0]), .addr_select_1(strap[1]), .addr_select_2(strap[2]),
      .channel_reg(channel_reg), .channel_connect(channel_connect));
   imx_link_properties u_imx_link_properties (.ref_clk(ref_clk), .nrst(nrst),
      .host_scl_o(link.host_scl_o), .host_scl_oe_n(link.host_scl_oe_n), .host_sda_o(link.host_sda_o),
      .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n),
      .scl(link.scl), .sda(link.sda));

   // Free-running system clock
   always #5 ref_clk = ~ref_clk;

   // One-hot pass-gate enables expected for a channel byte
   function automatic logic [7:0] exp_connect(input logic [7:0] c);
      exp_connect = c[imx_pkg::CH_EN_BIT] ? (8'h01 << c[2:0]) : 8'h00;
   endfunction

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One Avalon access; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rq);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= ~rd;
      avs_writedata <= wd;
      // Request stands until waitrequest is sampled low at a rising edge
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0)
      begin
         n++;
         if (n > 50)
         begin
            fail_count++;
            print_verdict();
         end
         @(posedge ref_clk);
      end
      rq = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // Issue one link command and poll status; selection must not move mid-frame
   task automatic xfer(input logic [6:0] sa, input logic rw, input logic [7:0] wd, input logic [7:0] old);
      int n;
      n = 0;
      bus(1'b0, imx_pkg::REG_CMD, {16'h0, wd, rw, sa}, q);
      do
      begin
         bus(1'b1, imx_pkg::REG_STATUS, 32'h0, q);
         if (link.scl === 1'b0)
            chk8("connect_in_frame", exp_connect(old), channel_connect);
         n++;
         if (n > 20000)
         begin
            fail_count++;
            print_verdict();
         end
      end
      while (q[imx_pkg::ST_BUSY_BIT] !== 1'b0);
      repeat (10) @(negedge ref_clk);
   endtask

   // Short pulse must be ignored, long one restores the default
   task automatic pin_reset(input int len);
      @(posedge ref_clk);
      rst_pin_n <= 1'b0;
      repeat (len) @(posedge ref_clk);
      rst_pin_n <= 1'b1;
      repeat (10) @(negedge ref_clk);
   endtask

   initial
   begin
      me = {imx_pkg::ADDR_HI, 3'($random(seed))};
      strap <= me[2:0];
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      @(negedge ref_clk);
      chk8("reg_reset", imx_pkg::CTRL_RESET, channel_reg);
      chk8("connect_reset", 8'h01, channel_connect);
      d1 = 8'($random(seed)) | 8'h08;
      xfer(me, 1'b0, d1, imx_pkg::CTRL_RESET);
      chk8("nack_write", 8'h00, {7'h0, q[imx_pkg::ST_NACK_BIT]});
      chk8("reg_write", d1, channel_reg);
      chk8("connect_write", exp_connect(d1), channel_connect);
      xfer(me, 1'b1, 8'h00, d1);
      bus(1'b1, imx_pkg::REG_RDATA, 32'h0, q);
      chk8("read_back", d1, q[7:0]);
      xfer(me ^ 7'h01, 1'b0, 8'h0b, d1);
      chk8("nack_wrong_addr", 8'h01, {7'h0, q[imx_pkg::ST_NACK_BIT]});
      chk8("reg_kept", d1, channel_reg);
      xfer(me, 1'b0, 8'hf7, d1);
      chk8("reg_no_channel", 8'hf7, channel_reg);
      chk8("connect_none", 8'h00, channel_connect);
      pin_reset(20);
      chk8("reg_short_pulse", 8'hf7, channel_reg);
      pin_reset(70);
      chk8("reg_pin_reset", imx_pkg::CTRL_RESET, channel_reg);
      chk8("connect_pin_reset", 8'h01, channel_connect);
      print_verdict();
   end
endmodule
